// ---- tas_host.sv ----
// Behavioural SMBus master for the bench.
`timescale 1ns/1ns
module tas_host (
	// Clock, then the bus wires.
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_h
);
	// Both wires rest high outside frames; the clock never runs there.
	initial begin
		scl = 1'b1;
		sda_h = 1'b1;
	end
	// Half of the 160 ns link period, moved on falling edges only.
	task automatic half();
		repeat (10) @(negedge clk);
	endtask : half
	// Start when b is 0, stop when b is 1: data moves while the clock is high.
	task automatic frame(input logic b);
		sda_h = !b;
		half();
		scl = 1'b1;
		half();
		sda_h = b;
		half();
		if (!b) scl = 1'b0;
	endtask : frame
	// Eight bits most significant first, then the ninth; a 1 lets the pull-up win.
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 8; i >= 0; i--) begin
			sda_h = (i > 0) ? d[i - 1] : a;
			half();
			scl = 1'b1;
			half();
			if (i > 0) q[i - 1] = sda;
			else k = sda;
			scl = 1'b0;
		end
	endtask : xfer
endmodule : tas_host

// ---- tas_pkg.sv ----
// Package of constants and carrier types for the thermal alarm SMBus target.
package tas_pkg;

	// Register pointer locations on the SMBus.
	localparam logic [7:0] TAS_PTR_RESET = 8'h00;
	localparam logic [7:0] TAS_REG_LOCAL_MSB = 8'h00;
	localparam logic [7:0] TAS_REG_REMOTE_MSB = 8'h01;
	localparam logic [7:0] TAS_REG_STATUS1 = 8'h02;
	localparam logic [7:0] TAS_REG_CFG1_RD = 8'h03;
	localparam logic [7:0] TAS_REG_CFG1_WR = 8'h09;
	localparam logic [7:0] TAS_REG_ROT_LIM_RD = 8'h07;
	localparam logic [7:0] TAS_REG_ROT_LIM_WR = 8'h0D;
	localparam logic [7:0] TAS_REG_ONE_SHOT = 8'h0F;
	localparam logic [7:0] TAS_REG_REMOTE_LSB = 8'h10;
	localparam logic [7:0] TAS_REG_RCRIT = 8'h19;
	localparam logic [7:0] TAS_REG_LOCAL_LIM = 8'h20;
	localparam logic [7:0] TAS_REG_HYST = 8'h21;
	localparam logic [7:0] TAS_REG_LOCAL_LSB = 8'h30;
	localparam logic [7:0] TAS_REG_REMOTE_UMSB = 8'h31;
	localparam logic [7:0] TAS_REG_REMOTE_ULSB = 8'h32;
	localparam logic [7:0] TAS_REG_CFG2 = 8'hBF;

	// Reset values of the writable registers.
	localparam logic [7:0] TAS_CFG1_RESET = 8'h00;
	localparam logic [7:0] TAS_CFG2_RESET = 8'h1F;
	localparam logic [7:0] TAS_ROT_LIM_RESET = 8'h55;
	localparam logic [7:0] TAS_LOCAL_LIM_RESET = 8'h55;
	localparam logic [7:0] TAS_RCRIT_RESET = 8'h6E;
	localparam logic [7:0] TAS_HYST_RESET = 8'h0A;

	// Field positions.
	localparam int TAS_CFG1_STANDBY_BIT = 6;
	localparam int TAS_CFG2_ALARM_SEL_BIT = 0;
	localparam int TAS_ST_BUSY_BIT = 7;
	localparam int TAS_ST_ROT_BIT = 4;
	localparam int TAS_ST_RCRIT_BIT = 3;
	localparam int TAS_ST_FAULT_BIT = 2;
	localparam int TAS_ST_LOCAL_BIT = 0;

	// Diode fault readings: -128.000 signed and +255.875 unsigned.
	localparam logic [15:0] TAS_FAULT_SIGNED = 16'h8000;
	localparam logic [15:0] TAS_FAULT_UNSIGNED = 16'hFFE0;

	// Bus timeout: 35 ms at 125 MHz.
	localparam int TAS_TIMEOUT_MS = 35;
	localparam int TAS_CLK_MHZ = 125;
	localparam int TAS_TIMEOUT_CYC = TAS_TIMEOUT_MS * 1000 * TAS_CLK_MHZ;

	// One conversion result pair from the analog front end.
	typedef struct packed {
		logic [15:0] local_t;
		logic [15:0] remote_t;
		logic fault;
	} tas_conv_s;

	// Open-drain pin: level to drive and output enable, low while driving.
	typedef struct packed {
		logic o;
		logic oe_n;
	} tas_od_s;

	typedef enum logic [2:0] {
		TAS_IDLE, TAS_ADDR, TAS_ACK, TAS_WRBYTE, TAS_RDBYTE, TAS_RDACK, TAS_IGNORE
	} tas_bus_e;

endpackage : tas_pkg

// ---- tas_top.sv ----
// SMBus target with temperature alarm comparators and readout lock.
`timescale 1ns/1ns

// Summary of operation
// (R1) Drive critical alarm low when local or remote result exceeds its critical limit.
// (R2) Release critical alarm only when both fall below limit minus hysteresis.
// (R3) Remote above remote critical limit sets remote critical status flag.
// (R4) Local above shared local limit sets local limit status flag.
// (R5) Alarms and flags refresh once after each local and remote conversion pair.
// (R6) Over-temperature output asserts when either result exceeds its limit, if selected.
// (R7) Remote above remote over-temperature limit sets remote over-temperature flag.
// (R8) Over-temperature output releases when both fall below limit minus hysteresis.
// (R9) Diode fault reports remote as -128.000 signed or +255.875 unsigned.
// (R10) Diode fault sets bit D2 of the first status register.
// (R11) Register pointer resets to 00 and holds the last value written.
// (R12) Master writes address, command byte, then exactly one data byte.
// (R13) Read with correct pointer is address byte then returned data byte.
// (R14) Different location: address, command, repeated start, address, then data.
// (R15) Data bytes travel most significant bit first.
// (R16) Acknowledge or not-acknowledge after a read byte are both accepted.
// (R17) Remote low byte freezes when high byte is read, unfreezes after low read.
// (R18) Bus logic returns to idle if clock or data stays low over 35 ms.
// (R19) Master forces timeout by holding clock or data low at least 35 ms.
// (R20) A start is recognised anywhere and an address byte is then expected.
// (R21) One-shot write in standby launches one conversion then returns to standby.
// (R22) One-shot data is discarded and the location always reads zero.
// (R23) One-shot starts a conversion only when the standby bit equals 1.
module tas_top #(
	parameter int TIMEOUT_CYC = tas_pkg::TAS_TIMEOUT_CYC,
	parameter logic [6:0] DEV_ADDR = 7'h4C
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// SMBus pins.
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	// Conversion interface to the analog front end.
	input wire logic conv_done,
	input wire tas_pkg::tas_conv_s conv_data,
	output logic conv_start,
	output logic conv_standby,
	// Alarm pins, active low open drain.
	output logic crit_o,
	output logic crit_oe_n,
	output logic overtemp_alarm_out,
	output logic overtemp_oe_n
);
	import tas_pkg::*;

	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic scl_d;
		logic sda_d;
		tas_bus_e st;
		logic [2:0] bitc;
		logic got8; // A whole byte has been shifted in since the last start or ack.
		logic [7:0] sh;
		logic rw;
		logic got_cmd;
		logic [7:0] pointer_bits;
		// Cycles without both lines high; a legal frame always returns to both high.
		logic [31:0] low_cnt;
		logic sda_drv;
		logic [7:0] cfg1;
		logic [7:0] cfg2;
		logic [7:0] rot_lim;
		logic [7:0] loc_lim;
		logic [7:0] rcrit_lim;
		logic [7:0] hyst;
		logic [15:0] loc_t;
		logic [15:0] rem_t;
		logic [15:0] rem_u;
		logic fault;
		logic [7:0] lsb_frz;
		logic [7:0] ulsb_frz;
		logic lock;
		logic crit;
		logic ot;
		logic remote_critical_flag;
		logic remote_overtemp_flag;
		logic local_limit_flag;
		logic busy;
		logic start;
		// Registered pin images, so no output passes through logic after its flop.
		tas_od_s sda_pin;
		tas_od_s crit_pin;
		tas_od_s ot_pin;
	} tas_state_s;

	tas_state_s s_r;
	tas_state_s s_nxt;

	// Integer degree part of a reading, saturated at zero for negative signed values.
	function automatic logic [8:0] tas_deg(input logic [15:0] t, input logic unsgn);
		if (!unsgn && t[15])
			tas_deg = 9'h000;
		else
			tas_deg = {1'b0, t[15:8]};
	endfunction : tas_deg

	// Above test: strictly greater than the limit.
	function automatic logic tas_above(input logic [8:0] d, input logic [7:0] lim);
		tas_above = d > {1'b0, lim};
	endfunction : tas_above

	// Below test against limit minus hysteresis; a limit under the hysteresis never releases.
	function automatic logic tas_below(input logic [8:0] d, input logic [7:0] lim,
			input logic [7:0] h);
		tas_below = ({1'b0, lim} >= {1'b0, h}) && (d < ({1'b0, lim} - {1'b0, h}));
	endfunction : tas_below

	// Register read multiplexer.
	function automatic logic [7:0] tas_rd(input tas_state_s s);
		case (s.pointer_bits)
			TAS_REG_LOCAL_MSB: tas_rd = s.loc_t[15:8];
			TAS_REG_LOCAL_LSB: tas_rd = s.loc_t[7:0];
			TAS_REG_REMOTE_MSB: tas_rd = s.rem_t[15:8];
			TAS_REG_REMOTE_LSB: tas_rd = s.lsb_frz;
			TAS_REG_REMOTE_UMSB: tas_rd = s.rem_u[15:8];
			TAS_REG_REMOTE_ULSB: tas_rd = s.ulsb_frz;
			TAS_REG_STATUS1: begin
				// Unused status bits read as zero.
				tas_rd = 8'h00;
				tas_rd[TAS_ST_BUSY_BIT] = s.busy;
				tas_rd[TAS_ST_ROT_BIT] = s.remote_overtemp_flag;
				tas_rd[TAS_ST_RCRIT_BIT] = s.remote_critical_flag;
				tas_rd[TAS_ST_FAULT_BIT] = s.fault; // [R10]
				tas_rd[TAS_ST_LOCAL_BIT] = s.local_limit_flag;
			end
			TAS_REG_CFG1_RD, TAS_REG_CFG1_WR: tas_rd = s.cfg1;
			TAS_REG_CFG2: tas_rd = s.cfg2;
			TAS_REG_ROT_LIM_RD, TAS_REG_ROT_LIM_WR: tas_rd = s.rot_lim;
			TAS_REG_RCRIT: tas_rd = s.rcrit_lim;
			TAS_REG_LOCAL_LIM: tas_rd = s.loc_lim;
			TAS_REG_HYST: tas_rd = s.hyst;
			default: tas_rd = 8'h00; // One-shot and unmapped read zero. [R22]
		endcase
	endfunction : tas_rd

	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic [8:0] ld;
	logic [8:0] rd;
	logic [7:0] rd_byte;

	// Edge and condition detect on the second synchroniser stage only.
	assign scl = s_r.scl_s[1];
	assign sda = s_r.sda_s[1];
	assign scl_rise = scl && !s_r.scl_d;
	assign scl_fall = !scl && s_r.scl_d;
	assign start_c = scl && s_r.scl_d && !sda && s_r.sda_d; // [R20]
	assign stop_c = scl && s_r.scl_d && sda && !s_r.sda_d;
	assign ld = tas_deg(conv_data.local_t, 1'b0);
	assign rd = tas_deg(conv_data.remote_t, 1'b1);
	// Byte the pointer selects, loaded into the shifter at the start of a read byte.
	assign rd_byte = tas_rd(s_r);

	// Next-state logic for the bus engine, registers and comparators.
	always_comb begin
		s_nxt = s_r;
		s_nxt.scl_s = {s_r.scl_s[0], scl_i};
		s_nxt.sda_s = {s_r.sda_s[0], sda_i};
		s_nxt.scl_d = scl;
		s_nxt.sda_d = sda;
		s_nxt.start = 1'b0;

		// Low-time watchdog; the counter saturates so a held line cannot wrap it.
		if (scl && sda)
			s_nxt.low_cnt = '0;
		else if (s_r.low_cnt < 32'(TIMEOUT_CYC))
			s_nxt.low_cnt = s_r.low_cnt + 32'd1;

		if (start_c) begin
			s_nxt.st = TAS_ADDR; // [R20]
			s_nxt.bitc = 3'd0;
			s_nxt.sda_drv = 1'b0;
			s_nxt.got_cmd = 1'b0;
			s_nxt.got8 = 1'b0;
		end else if (stop_c || s_r.low_cnt >= 32'(TIMEOUT_CYC)) begin
			s_nxt.st = TAS_IDLE; // [R18]
			s_nxt.sda_drv = 1'b0;
		end else begin
			case (s_r.st)
				TAS_ADDR, TAS_WRBYTE: begin
					if (scl_rise) begin
						s_nxt.sh = {s_r.sh[6:0], sda}; // [R15]
						s_nxt.bitc = s_r.bitc + 3'd1;
						// The eighth rising edge completes the byte; the fall after a start does not.
						if (s_r.bitc == 3'd7)
							s_nxt.got8 = 1'b1;
					end
					if (scl_fall && s_r.got8 && s_r.st == TAS_ADDR && s_r.sh[7:1] == DEV_ADDR) begin
						s_nxt.rw = s_r.sh[0];
						s_nxt.sda_drv = 1'b1;
						s_nxt.st = TAS_ACK;
					end else if (scl_fall && s_r.got8 && s_r.st == TAS_ADDR) begin
						s_nxt.st = TAS_IGNORE;
					end else if (scl_fall && s_r.got8) begin
						s_nxt.sda_drv = 1'b1;
						s_nxt.st = TAS_ACK;
						if (!s_r.got_cmd) begin
							s_nxt.pointer_bits = s_r.sh; // [R11] [R14]
							s_nxt.got_cmd = 1'b1;
						end else begin
							// Single data byte goes to the pointed register. [R12]
							case (s_r.pointer_bits)
								TAS_REG_CFG1_RD, TAS_REG_CFG1_WR: s_nxt.cfg1 = s_r.sh;
								TAS_REG_CFG2: s_nxt.cfg2 = s_r.sh;
								TAS_REG_ROT_LIM_RD, TAS_REG_ROT_LIM_WR: s_nxt.rot_lim = s_r.sh;
								TAS_REG_RCRIT: s_nxt.rcrit_lim = s_r.sh;
								TAS_REG_LOCAL_LIM: s_nxt.loc_lim = {1'b0, s_r.sh[6:0]};
								TAS_REG_HYST: s_nxt.hyst = {3'b000, s_r.sh[4:0]};
								TAS_REG_ONE_SHOT: // Data discarded. [R22]
									s_nxt.start = s_r.cfg1[TAS_CFG1_STANDBY_BIT] && !s_r.busy; // [R21] [R23]
								default: ;
							endcase
						end
					end
				end
				// Ninth clock: hold the acknowledge, then turn to the next byte.
				TAS_ACK: begin
					if (scl_fall) begin
						s_nxt.bitc = 3'd0;
						s_nxt.got8 = 1'b0;
						if (s_r.rw) begin
							s_nxt.sh = rd_byte; // [R13]
							s_nxt.sda_drv = !rd_byte[7]; // [R15]
							s_nxt.st = TAS_RDBYTE;
							// High byte read freezes low bytes, low byte read frees them. [R17]
							if (s_r.pointer_bits == TAS_REG_REMOTE_MSB ||
									s_r.pointer_bits == TAS_REG_REMOTE_UMSB)
								s_nxt.lock = 1'b1;
							else if (s_r.pointer_bits == TAS_REG_REMOTE_LSB ||
									s_r.pointer_bits == TAS_REG_REMOTE_ULSB)
								s_nxt.lock = 1'b0;
						end else begin
							s_nxt.sda_drv = 1'b0;
							s_nxt.st = TAS_WRBYTE;
						end
					end
				end
				// Shift out on each falling edge so data settles while the clock is low.
				TAS_RDBYTE: begin
					if (scl_fall) begin
						s_nxt.bitc = s_r.bitc + 3'd1;
						s_nxt.sh = {s_r.sh[6:0], 1'b0};
						s_nxt.sda_drv = (s_r.bitc == 3'd7) ? 1'b0 : !s_r.sh[6]; // [R15]
						if (s_r.bitc == 3'd7)
							s_nxt.st = TAS_RDACK;
					end
				end
				TAS_RDACK: begin
					// Acknowledge repeats the byte; not-acknowledge ends the read. [R16]
					if (scl_rise)
						s_nxt.st = sda ? TAS_IGNORE : TAS_ACK;
				end
				default: ;
			endcase
		end

		// Low bytes track the readings until a high-byte read freezes them. [R17]
		if (!s_r.lock) begin
			s_nxt.lsb_frz = s_r.rem_t[7:0];
			s_nxt.ulsb_frz = s_r.rem_u[7:0];
		end

		// Result pair arrival refreshes readings, flags and alarm outputs. [R5]
		if (conv_done) begin
			s_nxt.busy = 1'b0;
			s_nxt.loc_t = conv_data.local_t;
			s_nxt.fault = conv_data.fault; // [R10]
			s_nxt.rem_t = conv_data.fault ? TAS_FAULT_SIGNED : conv_data.remote_t; // [R9]
			s_nxt.rem_u = conv_data.fault ? TAS_FAULT_UNSIGNED : conv_data.remote_t; // [R9]
			s_nxt.remote_critical_flag = tas_above(rd, s_r.rcrit_lim); // [R3]
			s_nxt.remote_overtemp_flag = tas_above(rd, s_r.rot_lim); // [R7]
			s_nxt.local_limit_flag = tas_above(ld, s_r.loc_lim); // [R4]
			if (tas_above(ld, s_r.loc_lim) || tas_above(rd, s_r.rcrit_lim))
				s_nxt.crit = 1'b1; // [R1]
			else if (tas_below(ld, s_r.loc_lim, s_r.hyst) && tas_below(rd, s_r.rcrit_lim, s_r.hyst))
				s_nxt.crit = 1'b0; // [R2]
			if (tas_above(ld, s_r.loc_lim) || tas_above(rd, s_r.rot_lim))
				s_nxt.ot = 1'b1; // [R6]
			else if (tas_below(ld, s_r.loc_lim, s_r.hyst) && tas_below(rd, s_r.rot_lim, s_r.hyst))
				s_nxt.ot = 1'b0; // [R8]
		end
		// A request in the cycle of an arriving pair stays pending: the set wins.
		if (s_nxt.start)
			s_nxt.busy = 1'b1;

		// Pin images follow the next state, so pin timing matches the state register.
		s_nxt.sda_pin.o = 1'b0;
		s_nxt.sda_pin.oe_n = !s_nxt.sda_drv;
		s_nxt.crit_pin.o = 1'b0;
		s_nxt.crit_pin.oe_n = !s_nxt.crit; // [R1] [R2]
		s_nxt.ot_pin.o = 1'b0;
		// The shared pin only drives while it is selected as the alarm output. [R6]
		s_nxt.ot_pin.oe_n = !(s_nxt.ot && !s_nxt.cfg2[TAS_CFG2_ALARM_SEL_BIT]);
	end

	// State register; all fields take constants under reset.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.scl_s <= 2'b11;
			s_r.sda_s <= 2'b11;
			s_r.scl_d <= 1'b1;
			s_r.sda_d <= 1'b1;
			s_r.st <= TAS_IDLE;
			s_r.pointer_bits <= TAS_PTR_RESET; // [R11]
			s_r.cfg1 <= TAS_CFG1_RESET;
			s_r.cfg2 <= TAS_CFG2_RESET;
			s_r.rot_lim <= TAS_ROT_LIM_RESET;
			s_r.loc_lim <= TAS_LOCAL_LIM_RESET;
			s_r.rcrit_lim <= TAS_RCRIT_RESET;
			s_r.hyst <= TAS_HYST_RESET;
			// All pins released while reset is low.
			s_r.sda_pin.oe_n <= 1'b1;
			s_r.crit_pin.oe_n <= 1'b1;
			s_r.ot_pin.oe_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Every output is a flip-flop of the state record.
	assign sda_o = s_r.sda_pin.o;
	assign sda_oe_n = s_r.sda_pin.oe_n;
	assign crit_o = s_r.crit_pin.o;
	assign crit_oe_n = s_r.crit_pin.oe_n;
	assign overtemp_alarm_out = s_r.ot_pin.o;
	assign overtemp_oe_n = s_r.ot_pin.oe_n;
	assign conv_start = s_r.start;
	assign conv_standby = s_r.cfg1[TAS_CFG1_STANDBY_BIT];

endmodule : tas_top

// ---- tas_top_assertions.sv ----
// Port-level assertions for the thermal alarm SMBus target.
`timescale 1ns/1ns
module tas_chk #(
	parameter int TIMEOUT_CYC = tas_pkg::TAS_TIMEOUT_CYC
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Bus, conversion and alarm ports.
	input wire logic scl_i,
	input wire logic sda_oe_n,
	input wire logic conv_done,
	input wire tas_pkg::tas_conv_s conv_data,
	input wire logic conv_start,
	input wire logic conv_standby,
	input wire logic crit_oe_n,
	input wire logic overtemp_oe_n
);
	import tas_pkg::*;
	logic [7:0] rdeg, ldeg;
	logic ok, hot_c, cool_c, cool_o;
	int low_r, low_nxt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Limits stay at reset values, so the checker can use them; negative local counts as 0.
	assign rdeg = conv_data.remote_t[15:8];
	assign ldeg = conv_data.local_t[15] ? 8'h00 : conv_data.local_t[15:8];
	assign ok = conv_done && !conv_data.fault;
	assign hot_c = rdeg > TAS_RCRIT_RESET || ldeg > TAS_LOCAL_LIM_RESET;
	assign cool_c = rdeg < TAS_RCRIT_RESET - TAS_HYST_RESET
		&& ldeg < TAS_LOCAL_LIM_RESET - TAS_HYST_RESET;
	assign cool_o = rdeg < TAS_ROT_LIM_RESET - TAS_HYST_RESET
		&& ldeg < TAS_LOCAL_LIM_RESET - TAS_HYST_RESET;
	// Cycles the clock line has been low.
	always_comb low_nxt = scl_i ? 0 : low_r + 1;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) low_r <= 0;
		else low_r <= low_nxt;
	end
	crit_set_a: assert property (ok && hot_c |=> !crit_oe_n)
		else $error("critical alarm not asserted");
	crit_release_a: assert property (ok && cool_c |=> crit_oe_n)
		else $error("critical alarm not released");
	crit_band_a: assert property (ok && !hot_c && !cool_c |=> $stable(crit_oe_n))
		else $error("critical alarm moved inside the band");
	crit_refresh_a: assert property (!conv_done |=> $stable(crit_oe_n))
		else $error("critical alarm moved without a conversion");
	ot_release_a: assert property (ok && cool_o |=> overtemp_oe_n)
		else $error("over-temperature not released");
	start_pulse_a: assert property (conv_start |=> !conv_start)
		else $error("one-shot request too long");
	start_standby_a: assert property (conv_start |-> conv_standby)
		else $error("one-shot outside standby");
	sda_edge_a: assert property ($changed(sda_oe_n) |-> !scl_i)
		else $error("data moved while clock high");
	bus_timeout_a: assert property (low_r > TIMEOUT_CYC + 8 |-> sda_oe_n)
		else $error("data held after timeout");
	cover property (conv_start);
	cover property ($fell(crit_oe_n));
	cover property ($fell(overtemp_oe_n));
endmodule : tas_chk

// ---- test_tas_top.sv ----
// Self-checking bench for the thermal alarm SMBus target.
`timescale 1ns/1ns
module test_tas_top;
	import tas_pkg::*;
	// Short bus timeout, still above the longest low run of a legal frame.
	localparam int TO = 400;
	localparam logic [6:0] DEV = 7'h4C;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic conv_done = 1'b0;
	tas_conv_s conv_data = '0;
	logic scl, sda_h, sda_o, sda_oe_n, conv_start, conv_standby, crit_oe_n, ot_oe_n, k;
	logic crit_o, ot_o;
	logic [7:0] q;
	int error_cnt = 0;
	int checks = 0;
	int starts = 0;
	// Open-drain data wire with its pull-up.
	wire logic sda = sda_h & (sda_oe_n | sda_o);
	// Alarm pin levels with their pull-ups.
	wire logic crit_pin = crit_oe_n | crit_o;
	wire logic ot_pin = ot_oe_n | ot_o;
	// Clock, and a tally of one-shot requests.
	always #4 clk = ~clk;
	always @(negedge clk) if (conv_start === 1'b1) starts++;
	tas_top #(.TIMEOUT_CYC(TO), .DEV_ADDR(DEV)) tas_top_inst (.clk(clk), .rst_n(rst_n),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .conv_done(conv_done),
		.conv_data(conv_data), .conv_start(conv_start), .conv_standby(conv_standby),
		.crit_o(crit_o), .crit_oe_n(crit_oe_n), .overtemp_alarm_out(ot_o),
		.overtemp_oe_n(ot_oe_n));
	tas_host tas_host_inst (.clk(clk), .sda(sda), .scl(scl), .sda_h(sda_h));
	// Byte compare; an unknown never matches.
	task automatic chk(input logic [7:0] got, exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD at %0t: got %h, want %h", $time, got, exp);
		end
	endtask : chk
	// Alarm pins as {critical, over-temperature}.
	task automatic pins(input logic [7:0] e);
		chk({6'h00, crit_pin, ot_pin}, e);
	endtask : pins
	// One finished conversion pair.
	task automatic cv(input logic [15:0] l, r, input logic f = 1'b0);
		@(negedge clk);
		conv_data = {l, r, f};
		conv_done = 1'b1;
		@(negedge clk);
		conv_done = 1'b0;
		@(negedge clk);
	endtask : cv
	// Register write; each of the three bytes must be acknowledged.
	task automatic wr(input logic [7:0] a, d);
		logic [2:0] ak;
		tas_host_inst.frame(1'b0);
		tas_host_inst.xfer({DEV, 1'b0}, 1'b1, q, ak[2]);
		tas_host_inst.xfer(a, 1'b1, q, ak[1]);
		tas_host_inst.xfer(d, 1'b1, q, ak[0]);
		tas_host_inst.frame(1'b1);
		chk({5'h00, ak}, 8'h00);
	endtask : wr
	// Read n bytes, setting the pointer first when c is 1; only the last is refused.
	task automatic rd(input bit c, input logic [7:0] a, e, input int n = 1,
			input logic [7:0] m = 8'hFF);
		if (c) begin
			tas_host_inst.frame(1'b0);
			tas_host_inst.xfer({DEV, 1'b0}, 1'b1, q, k);
			tas_host_inst.xfer(a, 1'b1, q, k);
		end
		tas_host_inst.frame(1'b0);
		tas_host_inst.xfer({DEV, 1'b1}, 1'b1, q, k);
		for (int i = 0; i < n; i++) begin
			tas_host_inst.xfer(8'hFF, i == n - 1, q, k);
			chk(q & m, e);
		end
		tas_host_inst.frame(1'b1);
	endtask : rd
	// Counts, verdict and end of run.
	task automatic results();
		$display("checks %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results
	// Watchdog: the tests need about 120 us.
	initial begin
		#400_000;
		error_cnt++;
		results();
	end
	// Test sequence.
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		cv(16'h2000, 16'h7000);
		pins(8'h01);
		rd(0, 8'h00, 8'h20);
		rd(1, TAS_REG_HYST, 8'h0A, 2);
		rd(1, TAS_REG_STATUS1, 8'h18);
		wr(TAS_REG_CFG2, 8'h1E);
		cv(16'h2000, 16'h7000);
		pins(8'h00);
		cv(16'h2000, 16'h6900);
		pins(8'h00);
		cv(16'h2000, 16'h6300);
		pins(8'h02);
		cv(16'h2000, 16'h4000);
		pins(8'h03);
		cv(16'h5600, 16'h4000);
		pins(8'h00);
		rd(1, TAS_REG_STATUS1, 8'h01);
		$display("alarm test done");
		cv(16'h2000, 16'h4000, 1'b1);
		rd(1, TAS_REG_STATUS1, 8'h04, 1, 8'h04);
		rd(1, TAS_REG_REMOTE_MSB, 8'h80);
		rd(1, TAS_REG_REMOTE_LSB, 8'h00);
		rd(1, TAS_REG_REMOTE_UMSB, 8'hFF);
		rd(1, TAS_REG_REMOTE_ULSB, 8'hE0);
		cv(16'h2000, 16'h4020);
		rd(1, TAS_REG_REMOTE_MSB, 8'h40);
		cv(16'h2000, 16'h5040);
		rd(1, TAS_REG_REMOTE_LSB, 8'h20);
		rd(1, TAS_REG_REMOTE_LSB, 8'h40);
		$display("fault and lock test done");
		wr(TAS_REG_ONE_SHOT, 8'hA5);
		chk(starts[7:0], 8'h00);
		wr(TAS_REG_CFG1_WR, 8'h40);
		wr(TAS_REG_ONE_SHOT, 8'hA5);
		chk({starts[6:0], conv_standby}, 8'h03);
		rd(1, TAS_REG_ONE_SHOT, 8'h00);
		cv(16'h2000, 16'h4000);
		$display("one-shot test done");
		rd(1, TAS_REG_HYST, 8'h0A);
		tas_host_inst.frame(1'b0);
		tas_host_inst.xfer({DEV, 1'b1}, 1'b1, q, k);
		repeat (8) @(negedge clk);
		chk({7'h00, sda}, 8'h00);
		repeat (TO + 20) @(negedge clk);
		chk({7'h00, sda}, 8'h01);
		tas_host_inst.frame(1'b1);
		rd(0, 8'h00, 8'h0A);
		$display("timeout test done");
		results();
	end
endmodule : test_tas_top
bind tas_top tas_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) tas_chk_inst (.clk(clk), .rst_n(rst_n),
	.scl_i(scl_i), .sda_oe_n(sda_oe_n), .conv_done(conv_done), .conv_data(conv_data),
	.conv_start(conv_start), .conv_standby(conv_standby), .crit_oe_n(crit_oe_n),
	.overtemp_oe_n(overtemp_oe_n));
